// ===== rtl/csq_divider.sv
// Serial restoring divider, one quotient bit per clock.
// Assumes operands are stable from start until done; divisor nonzero.
`timescale 1ns/1ps

module csq_divider
#(
	parameter int W = 80
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Request
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	// Result
	output logic              busy,
	output logic              done,
	output logic [W-1:0]      quotient
);
	logic [W-1:0] rem_q;
	logic [6:0]   cnt_q;
	logic [W:0]   shifted;
	logic [W:0]   diff;
	logic         fits;

	assign shifted = {rem_q, quotient[W-1]};
	assign diff    = shifted - {1'b0, divisor};
	assign fits    = !diff[W];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rem_q    <= '0;
			quotient <= '0;
			cnt_q    <= 7'h00;
			busy     <= 1'b0;
			done     <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				rem_q    <= '0;
				quotient <= dividend;
				cnt_q    <= 7'(W);
				busy     <= 1'b1;
			end
			else if (busy)
			begin
				rem_q    <= fits ? diff[W-1:0] : shifted[W-1:0];
				quotient <= {quotient[W-2:0], fits};
				cnt_q    <= cnt_q - 7'h01;
				busy     <= (cnt_q != 7'h01);
				done     <= (cnt_q == 7'h01);
			end
		end
	end
endmodule : csq_divider

// ===== rtl/csq_pkg.sv
// Types shared by the quantizer modules.
// Assumes csq_regs.svh is on the include path.
`include "csq_regs.svh"

package csq_pkg;

	typedef enum logic [1:0]
	{
		CSQ_IDLE = 2'b00,
		CSQ_DIV  = 2'b01,
		CSQ_PUSH = 2'b10
	} csq_state_t;

	typedef struct packed
	{
		logic        sign;
		logic [6:0]  planes;
		logic [3:0]  band;
		logic [31:0] mag;
	} csq_word_t;

endpackage : csq_pkg

// ===== rtl/csq_regs.svh
// Register offsets, field positions, reset values and counts of the quantizer.
// Included by the package and the top module; definitions only.
`ifndef CSQ_REGS_SVH
`define CSQ_REGS_SVH

// Byte offsets on the register bus
`define CSQ_OFF_CTRL     8'h00
`define CSQ_OFF_BANDSEL  8'h04
`define CSQ_OFF_BANDCFG  8'h08
`define CSQ_OFF_HDR      8'h0C
`define CSQ_OFF_STATUS   8'h10

// Control register fields
`define CSQ_CTRL_REV     0
`define CSQ_CTRL_RCT     1
`define CSQ_CTRL_ROI     2
`define CSQ_CTRL_GUARD   4
`define CSQ_CTRL_ROISH   8
`define CSQ_CTRL_DEPTH   16
`define CSQ_CTRL_RESET   32'h0008_0020

// Sub-band entry fields
`define CSQ_CFG_EXP      0
`define CSQ_CFG_MANT     5
`define CSQ_CFG_GAIN     16
`define CSQ_CFG_RESET    18'h00000

// Header word layout in irreversible mode
`define CSQ_HDR_EXP      11

// Arithmetic sizes
`define CSQ_MANT_BITS    11
`define CSQ_DIV_W        80
`define CSQ_NUM_BANDS    16
`define CSQ_MAG_BITS     32

`endif

// ===== rtl/csq_skid.sv
// Two-entry buffer; both outgoing sides come straight from flip-flops.
// Assumes the sink may stall for any number of cycles.
`timescale 1ns/1ps

module csq_skid
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Streams
	csq_stream_if.snk inS,
	csq_stream_if.src outS
);
	import csq_pkg::*;

	csq_word_t spare_q;
	logic      spareV_q;
	logic      headV_q;
	csq_word_t head_q;
	logic      pop;
	logic      push;

	assign pop        = headV_q && outS.ready;
	assign push       = inS.valid && !spareV_q;
	assign inS.ready  = !spareV_q;
	assign outS.valid = headV_q;
	assign outS.data  = head_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			head_q   <= '0;
			spare_q  <= '0;
			headV_q  <= 1'b0;
			spareV_q <= 1'b0;
		end
		else if (pop && spareV_q)
		begin
			head_q   <= spare_q;
			spareV_q <= 1'b0;
		end
		else if (push && (pop || !headV_q))
		begin
			head_q  <= inS.data;
			headV_q <= 1'b1;
		end
		else if (push)
		begin
			spare_q  <= inS.data;
			spareV_q <= 1'b1;
		end
		else if (pop)
			headV_q <= 1'b0;
	end
endmodule : csq_skid

// ===== rtl/csq_stream_if.sv
// Valid/ready carrier for quantized words between the quantizer modules.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps

interface csq_stream_if;
	import csq_pkg::*;
	logic      valid;
	logic      ready;
	csq_word_t data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : csq_stream_if

// ===== rtl/csq_top.sv
// Scalar quantizer for wavelet coefficients with APB register access.
// Assumes a synchronous upstream stream and a downstream that may stall.
//
// Behaviour
// - Each coefficient leaves as its sign and its magnitude over the band step, floored.
// - The band step is two to the range minus exponent times one plus mantissa over 2^11.
// - The magnitude is held in a bounded width and saturates rather than overflows.
// - The magnitude width in bit-planes is guard bits plus exponent minus one.
// - The guard-bit count is programmable in the control register; the header word does not carry it.
// - With region of interest enabled the plane count grows by the programmed shift.
// - Reversible mode uses a step of one, so magnitudes pass through unchanged up to the plane bound.
// - In reversible mode the header word carries the exponent and no mantissa.
// - In irreversible mode an active colour transform grows the nominal range by one bit.
`timescale 1ns/1ps
`include "csq_regs.svh"

module csq_top
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Coefficients in
	input  wire logic        coefValid,
	input  wire logic [31:0] coefData,
	input  wire logic [3:0]  coefBand,
	output logic             coefReady,
	// Quantized words out
	output logic             qValid,
	input  wire logic        qReady,
	output logic             qSign,
	output logic [31:0]      qMag,
	output logic [3:0]       qBand,
	output logic [6:0]       qPlanes
);
	import csq_pkg::*;

	csq_stream_if bufIn ();
	csq_stream_if bufOut ();

	csq_state_t   state_q;
	csq_state_t   state_d;
	logic [31:0]  ctrl_q;
	logic [3:0]   bandSel_q;
	logic [17:0]  bandTab [`CSQ_NUM_BANDS];
	logic [15:0]  count_q;
	logic [31:0]  absVal_q;
	logic         sign_q;
	logic [3:0]   band_q;
	logic [4:0]   exp_q;
	logic [10:0]  mant_q;
	logic [5:0]   range_q;
	logic [6:0]   planes_q;
	logic [31:0]  mag_q;
	logic         divStart_q;

	// Control fields
	wire         revMode  = ctrl_q[`CSQ_CTRL_REV];
	wire         rctOn    = ctrl_q[`CSQ_CTRL_RCT];
	wire         roiOn    = ctrl_q[`CSQ_CTRL_ROI];
	wire  [2:0]  guard    = ctrl_q[`CSQ_CTRL_GUARD +: 3];
	wire  [4:0]  roiShift = ctrl_q[`CSQ_CTRL_ROISH +: 5];
	wire  [4:0]  depth    = ctrl_q[`CSQ_CTRL_DEPTH +: 5];

	// APB decode; a write lands only on the completing edge
	wire         apbAcc   = psel && penable && !pready;
	wire         apbDone  = psel && penable && pready;
	wire         selCtrl  = paddr == `CSQ_OFF_CTRL;
	wire         selSel   = paddr == `CSQ_OFF_BANDSEL;
	wire         selCfg   = paddr == `CSQ_OFF_BANDCFG;
	wire         selHdr   = paddr == `CSQ_OFF_HDR;
	wire         selStat  = paddr == `CSQ_OFF_STATUS;
	wire         addrOk   = selCtrl || selSel || selCfg || selHdr || selStat;
	wire         cfgBusy  = selCfg && pwrite && (state_q != CSQ_IDLE);
	wire         wrEn     = apbDone && pwrite && !pslverr;

	// Selected table entry and its header word
	wire  [17:0] selEntry = bandTab[bandSel_q];
	wire  [4:0]  selExp   = selEntry[`CSQ_CFG_EXP +: 5];
	wire  [10:0] selMant  = selEntry[`CSQ_CFG_MANT +: `CSQ_MANT_BITS];
	wire  [31:0] hdrWord  = revMode ? {27'h0, selExp}
	                                : {16'h0, selExp, selMant};

	logic [31:0] rdMux;
	assign rdMux = selCtrl ? ctrl_q :
	               selSel  ? {28'h0, bandSel_q} :
	               selCfg  ? {14'h0, selEntry} :
	               selHdr  ? hdrWord :
	               selStat ? {15'h0, state_q != CSQ_IDLE, count_q} : 32'h0000_0000;

	// Coefficient capture
	wire         accept   = (state_q == CSQ_IDLE) && coefValid && coefReady;
	wire  [17:0] inEntry  = bandTab[coefBand];
	wire  [4:0]  inExp    = inEntry[`CSQ_CFG_EXP +: 5];
	wire  [1:0]  inGain   = inEntry[`CSQ_CFG_GAIN +: 2];
	wire  [31:0] inAbs    = coefData[31] ? 32'(-coefData) : coefData;
	wire  [5:0]  inRange  = revMode ? {1'b0, inExp}
	                      : 6'({1'b0, depth} + {4'h0, inGain} + {5'h0, rctOn});
	wire  [7:0]  planeSum = 8'({5'h0, guard} + {3'h0, inExp}
	                      + (roiOn ? {3'h0, roiShift} : 8'h00));
	wire  [6:0]  inPlanes = (planeSum == 8'h00) ? 7'h00 : 7'(planeSum - 8'h01);

	// Step as shifted divisor; a negative shift moves onto the dividend
	wire         upShift  = {1'b0, exp_q} > range_q;
	wire  [5:0]  numShift = upShift ? 6'({1'b0, exp_q} - range_q) : 6'h00;
	wire  [5:0]  denShift = upShift ? 6'h00 : 6'(range_q - {1'b0, exp_q});
	wire  [`CSQ_DIV_W-1:0] dividend = `CSQ_DIV_W'(absVal_q) << (7'd11 + 7'(numShift));
	wire  [`CSQ_DIV_W-1:0] divisor  = `CSQ_DIV_W'({1'b1, mant_q}) << denShift;
	wire  [`CSQ_DIV_W-1:0] quotient;
	wire         divDone;

	// Magnitude bound from the plane count
	wire  [31:0] limit    = (planes_q >= 7'd32) ? 32'hFFFF_FFFF
	                      : 32'((33'h1 << planes_q) - 33'h1);
	wire  [31:0] divSat   = (quotient > `CSQ_DIV_W'(limit)) ? limit : quotient[31:0];
	wire  [31:0] inLimit  = (inPlanes >= 7'd32) ? 32'hFFFF_FFFF
	                      : 32'((33'h1 << inPlanes) - 33'h1);
	wire  [31:0] revSat   = (inAbs > inLimit) ? inLimit : inAbs;

	assign state_d = (state_q == CSQ_IDLE && accept) ? (revMode ? CSQ_PUSH : CSQ_DIV) :
	                 (state_q == CSQ_DIV && divDone) ? CSQ_PUSH :
	                 (state_q == CSQ_PUSH && bufIn.ready) ? CSQ_IDLE : state_q;

	assign bufIn.valid = state_q == CSQ_PUSH;
	assign bufIn.data  = '{sign: sign_q, planes: planes_q, band: band_q, mag: mag_q};

	csq_divider #(.W(`CSQ_DIV_W)) divider
	(
		.clk      (clk),
		.rst      (rst),
		.start    (divStart_q),
		.dividend (dividend),
		.divisor  (divisor),
		.busy     (),
		.done     (divDone),
		.quotient (quotient)
	);

	csq_skid outBuf
	(
		.clk  (clk),
		.rst  (rst),
		.inS  (bufIn),
		.outS (bufOut)
	);

	assign bufOut.ready = qReady;

	// Outputs that mirror buffer flops
	assign qValid  = bufOut.valid;
	assign qSign   = bufOut.data.sign;
	assign qMag    = bufOut.data.mag;
	assign qBand   = bufOut.data.band;
	assign qPlanes = bufOut.data.planes;

	// Bus side; two-cycle access so read data leaves a flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			prdata    <= 32'h0000_0000;
			ctrl_q    <= `CSQ_CTRL_RESET;
			bandSel_q <= 4'h0;
		end
		else
		begin
			pready  <= apbAcc;
			pslverr <= apbAcc && (!addrOk || cfgBusy || (pwrite && (selHdr || selStat)));
			prdata  <= (apbAcc && !pwrite) ? rdMux : 32'h0000_0000;
			if (wrEn && selCtrl)
				ctrl_q <= pwdata;
			if (wrEn && selSel)
				bandSel_q <= pwdata[3:0];
		end
	end

	// Table entries hold no reset; software loads them before streaming
	always_ff @(posedge clk)
	begin
		if (wrEn && selCfg)
			bandTab[bandSel_q] <= pwdata[17:0];
	end

	// Datapath; band parameters frozen per coefficient
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q    <= CSQ_IDLE;
			coefReady  <= 1'b0;
			divStart_q <= 1'b0;
			absVal_q   <= 32'h0000_0000;
			sign_q     <= 1'b0;
			band_q     <= 4'h0;
			exp_q      <= 5'h00;
			mant_q     <= 11'h000;
			range_q    <= 6'h00;
			planes_q   <= 7'h00;
			mag_q      <= 32'h0000_0000;
			count_q    <= 16'h0000;
		end
		else
		begin
			state_q    <= state_d;
			coefReady  <= state_d == CSQ_IDLE;
			divStart_q <= accept && !revMode;
			if (accept)
			begin
				absVal_q <= inAbs;
				sign_q   <= coefData[31] && (inAbs != 32'h0000_0000);
				band_q   <= coefBand;
				exp_q    <= inExp;
				mant_q   <= revMode ? 11'h000 : inEntry[`CSQ_CFG_MANT +: `CSQ_MANT_BITS];
				range_q  <= inRange;
				planes_q <= inPlanes;
			end
			if (state_q == CSQ_DIV && divDone)
				mag_q <= divSat;
			else if (state_q == CSQ_IDLE && state_d == CSQ_PUSH)
				mag_q <= revSat;
			else if (state_q == CSQ_PUSH)
				mag_q <= mag_q;
			if (state_q == CSQ_PUSH && bufIn.ready)
				count_q <= count_q + 16'h0001;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sqIrrAccept;
		accept && !revMode;
	endsequence

	sequence sqDivRun;
		divStart_q ##81 divDone;
	endsequence

	rev_pass_a: assert property (accept && revMode |=> state_q == CSQ_PUSH
		&& mag_q == (($past(inAbs) > limit) ? limit : $past(inAbs)))
		else $error("reversible magnitude not passed");

	div_path_a: assert property (sqIrrAccept |=> sqDivRun)
		else $error("divider not run for irreversible coefficient");

	sign_keep_a: assert property (accept |=> sign_q == ($past(coefData[31])
		&& $past(coefData) != 32'h0)) else $error("sign not captured");

	mag_bound_a: assert property (bufIn.valid |-> bufIn.data.mag <= limit)
		else $error("magnitude beyond plane bound");

	plane_count_a: assert property (accept && !roiOn && (guard + inExp) != 0
		|=> planes_q == 7'($past(guard) + $past(inExp) - 1)) else $error("plane count wrong");

	roi_planes_a: assert property (accept && roiOn && (guard + inExp + roiShift) != 0
		|=> planes_q == 7'($past(guard) + $past(inExp) + $past(roiShift) - 1))
		else $error("region of interest planes wrong");

	rct_range_a: assert property (accept && !revMode |=> range_q == 6'($past(depth)
		+ $past(inGain) + $past(rctOn))) else $error("nominal range wrong");

	hdr_rev_a: assert property (revMode |-> hdrWord[31:5] == 27'h0)
		else $error("mantissa in reversible header");

	band_hold_a: assert property (state_q != CSQ_IDLE |=> $stable(exp_q)
		&& $stable(mant_q)) else $error("band parameters changed in flight");
endmodule : csq_top

// ===== tb/coefficient_scalar_quantizer_test.sv
// Self-checking bench for the quantizer: APB setup, stream checks.
// Assumes csq_top and csq_far_model are compiled first.
`timescale 1ns/1ps
`define CSQ_CHK(a, b) begin nChecks++; if ((a) !== (b)) begin nFail++; \
	$display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module coefficient_scalar_quantizer_test;
	import csq_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, coefData, qMag, rd;
	logic        pready, pslverr, coefValid, coefReady, qValid, qReady, qSign, er;
	logic [3:0]  coefBand, qBand;
	logic [6:0]  qPlanes;
	int          nFail = 0;
	int          nChecks = 0;
	int          stepExp;
	int          stepMant;
	int          cycles = 0;

	always #12.5 clk = ~clk;

	csq_top dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .coefValid(coefValid), .coefData(coefData),
		.coefBand(coefBand), .coefReady(coefReady), .qValid(qValid), .qReady(qReady),
		.qSign(qSign), .qMag(qMag), .qBand(qBand), .qPlanes(qPlanes));

	csq_far_model far (.clk(clk), .coefValid(coefValid), .coefData(coefData),
		.coefBand(coefBand), .coefReady(coefReady), .qValid(qValid), .qReady(qReady),
		.qSign(qSign), .qMag(qMag), .qBand(qBand), .qPlanes(qPlanes));

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic getWord(output csq_word_t w);
		while (far.got.size() == 0)
			@(posedge clk);
		w = far.got.pop_front();
	endtask : getWord

	// One coefficient through a freshly loaded band 3
	task automatic quant(input bit rev, reversible_colour_transform, roi, input int g, sh, dep, ex, mt, gn, a);
		int        rb;
		int        pl;
		longint    m;
		csq_word_t w;
		apb(1'b1, 8'h00, {11'h0, dep[4:0], 3'h0, sh[4:0], 1'b0, g[2:0], 1'b0, roi, reversible_colour_transform, rev});
		apb(1'b1, 8'h04, 32'h3);
		apb(1'b1, 8'h08, {14'h0, gn[1:0], mt[10:0], ex[4:0]});
		apb(1'b0, 8'h0C, 32'h0);
		`CSQ_CHK(rd, (rev ? {27'h0, ex[4:0]} : {16'h0, ex[4:0], mt[10:0]}))
		far.sendCoef(a, 4'h3);
		getWord(w);
		rb = rev ? ex : dep + gn + reversible_colour_transform;
		pl = g + ex - 1 + (roi ? sh : 0);
		m  = longint'(a < 0 ? -a : a) * 2048;
		if (rb >= ex)
			m = m / (longint'(2048 + (rev ? 0 : mt)) << (rb - ex));
		else
			m = (m << (ex - rb)) / longint'(2048 + (rev ? 0 : mt));
		if (m > (64'h1 << pl) - 1)
			m = (64'h1 << pl) - 1;
		`CSQ_CHK(w.mag, m[31:0])
		`CSQ_CHK(w.sign, a < 0)
		`CSQ_CHK(w.planes, pl[6:0])
		`CSQ_CHK(w.band, 4'h3)
	endtask : quant

	// Two words parked in the buffer, a third held in the push stage, further input refused, none lost
	task automatic stallFill();
		csq_word_t w;
		far.stall = 1'b1;
		fork
			begin
				far.sendCoef(32'h5, 4'h3);
				far.sendCoef(32'h6, 4'h3);
				far.sendCoef(32'h7, 4'h3);
			end
			begin
				repeat (40) @(posedge clk);
				`CSQ_CHK(qValid, 1'b1)
				`CSQ_CHK(coefReady, 1'b0)
				`CSQ_CHK(far.got.size(), 0)
				far.stall = 1'b0;
			end
		join
		for (int i = 5; i < 8; i++)
		begin
			getWord(w);
			`CSQ_CHK(w.mag, 32'(i))
		end
	endtask : stallFill

	task automatic completeRun();
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : completeRun

	// Ceiling well above the several hundred cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			nFail++;
			completeRun();
		end
	end

	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0);
		`CSQ_CHK(rd, 32'h0008_0020)
		apb(1'b0, 8'h14, 32'h0);
		`CSQ_CHK(er, 1'b1)
		apb(1'b1, 8'h0C, 32'h1);
		`CSQ_CHK(er, 1'b1)
		quant(1, 0, 0, 2, 0, 8, 5, 7, 0, -37);
		stallFill();
		quant(1, 0, 0, 1, 0, 8, 2, 0, 0, 1000);
		quant(0, 0, 0, 1, 0, 8, 8, 1024, 0, 100);
		quant(0, 1, 0, 1, 0, 8, 8, 1024, 0, 100);
		quant(0, 0, 1, 2, 3, 8, 6, 0, 2, -100);
		far.stepFor(8, stepExp, stepMant);
		quant(0, 0, 0, 2, 0, 8, stepExp, stepMant, 1, 300);
		completeRun();
	end
endmodule : coefficient_scalar_quantizer_test

// ===== tb/csq_far_model.sv
// Far side of the quantizer: coefficient source and stalling sink.
// Assumes one clock; the bench sets stall and calls sendCoef.
`timescale 1ns/1ps

module csq_far_model
	import csq_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// Coefficient source
	output logic             coefValid,
	output logic [31:0]      coefData,
	output logic [3:0]       coefBand,
	input  wire logic        coefReady,
	// Quantized sink
	input  wire logic        qValid,
	output logic             qReady,
	input  wire logic        qSign,
	input  wire logic [31:0] qMag,
	input  wire logic [3:0]  qBand,
	input  wire logic [6:0]  qPlanes
);
	logic      stall = 1'b0;
	csq_word_t got[$];

	initial
	begin
		coefValid = 1'b0;
		coefData  = 32'h0;
		coefBand  = 4'h0;
		qReady    = 1'b0;
	end

	// Held until taken; stale data inverted so reuse shows
	task automatic sendCoef(input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		coefValid <= 1'b1;
		coefData  <= d;
		coefBand  <= b;
		do
			@(posedge clk);
		while (coefReady !== 1'b1);
		coefValid <= 1'b0;
		coefData  <= ~d;
	endtask : sendCoef

	// Synthesis impulse responses; both symmetric about tap zero
	function automatic real tapOf(input bit hi, input int i);
		int k;
		k = (i < 0) ? -i : i;
		if (hi)
			case (k)
				0: return 0.6029490182363579;
				1: return -0.2668641184428723;
				2: return -0.07822326652898785;
				3: return 0.01686411844287495;
				4: return 0.02674875741080976;
				default: return 0.0;
			endcase
		else
			case (k)
				0: return 1.115087052456994;
				1: return 0.5912717631142470;
				2: return -0.05754352622849957;
				3: return -0.09127176311424948;
				default: return 0.0;
			endcase
	endfunction : tapOf

	// Upsample, convolve with the next low-pass, then sum the squares
	function automatic real dirWeight(input bit hiFirst, input int nFilt);
		real cur [0:127];
		real nxt [0:127];
		int  len;
		real acc;
		len = hiFirst ? 9 : 7;
		for (int i = 0; i < 128; i++)
			cur[i] = 0.0;
		for (int i = 0; i < len; i++)
			cur[i] = tapOf(hiFirst, i - len / 2);
		for (int f = 1; f < nFilt; f++)
		begin
			for (int i = 0; i < 128; i++)
				nxt[i] = 0.0;
			for (int i = 0; i < len; i++)
				for (int j = -3; j <= 3; j++)
					nxt[2 * i + j + 3] += cur[i] * tapOf(1'b0, j);
			len = 2 * len + 5;
			cur = nxt;
		end
		acc = 0.0;
		for (int i = 0; i < len; i++)
			acc += cur[i] * cur[i];
		return acc;
	endfunction : dirWeight

	// Suggested step of a level-three low-high band as exponent and mantissa
	task automatic stepFor(input int depthBits, output int ex, output int mt);
		real rowW;
		real colW;
		real gamma;
		real step;
		rowW  = dirWeight(1'b0, 3);
		colW  = dirWeight(1'b1, 3);
		gamma = rowW * colW;
		step  = 2.0 ** (1 - depthBits);
		step  = step * (2.0 ** (depthBits + 1)) / $sqrt(gamma);
		ex    = depthBits + 1;
		while (step >= 2.0)
		begin
			step = step / 2.0;
			ex--;
		end
		while (step < 1.0)
		begin
			step = step * 2.0;
			ex++;
		end
		mt = $rtoi((step - 1.0) * 2048.0);
	endtask : stepFor

	always @(posedge clk)
	begin
		if (qValid === 1'b1 && qReady)
			got.push_back(csq_word_t'({qSign, qPlanes, qBand, qMag}));
		qReady <= !stall;
	end
endmodule : csq_far_model
